// ===== shared/trace_params.svh
/*
  Offsets, field positions, reset values and widths of the bus trace buffer.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef TRACE_PARAMS_SVH
`define TRACE_PARAMS_SVH

// buffer geometry
`define TRC_DEPTH        2047
`define TRC_LAST_INDEX   11'h7fe
`define TRC_PTR_W        11
`define TRC_ENTRY_W      104

// entry field positions, low bit first
`define TRC_TS_LSB       0
`define TRC_TS_W         64
`define TRC_FLAG_LSB     64
`define TRC_STATE_LSB    66
`define TRC_STATE_W      4
`define TRC_PROBE_LSB    70
`define TRC_PROBE_W      8
`define TRC_KIND_LSB     78
`define TRC_DATA_LSB     80
`define TRC_ADDR_LSB     88

// register byte addresses
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_INDEX        8'h08
`define REG_SAMPLE0      8'h0c
`define REG_SAMPLE1      8'h10
`define REG_SAMPLE2      8'h14
`define REG_SAMPLE3      8'h18
`define REG_IRQ_STAT     8'h1c
`define REG_IRQ_MASK     8'h20
`define REG_TSTAMP       8'h24
`define REG_T1_VALUE     8'h28
`define REG_T1_TOTAL     8'h2c
`define REG_T1_STARTS    8'h30
`define REG_T2_VALUE     8'h34
`define REG_T2_TOTAL     8'h38

// control bits
`define CTRL_ENABLE      0
`define CTRL_CLEAR       1
`define CTRL_T1_EN       2
`define CTRL_T2_EN       3
`define CTRL_T_CLEAR     4
`define CTRL_RESET       32'h0000_0000

// interrupt bits
`define IRQ_WRAP         0
`define IRQ_LAST         1
`define IRQ_T1_STOP      2
`define IRQ_T2_STOP      3
`define IRQ_W            4

// status bits above the count
`define STAT_FULL        16
`define STAT_ENABLE      17

`endif

// ===== shared/trace_pkg.sv
/*
  Types shared by the bus trace buffer, its bus model and its bench.
  Assumes trace_params.svh on the include path.
*/
`include "trace_params.svh"

package trace_pkg;

  // kind of the captured bus cycle
  typedef enum logic [1:0] {
    CYC_READ                    = 2'h0,
    CYC_WRITE                   = 2'h1,
    instruction_fetch_cycle     = 2'h2
  } cycle_kind_t;

  // flag field of an entry
  typedef enum logic [1:0] {
    FLAG_NONE  = 2'h0,
    FLAG_EVENT = 2'h1,
    FLAG_LAST  = 2'h2
  } trace_flag_t;

  typedef logic [`TRC_ENTRY_W-1:0] entry_t;
  typedef logic [`TRC_PTR_W-1:0]   ptr_t;

endpackage

// ===== core/interval_timer.sv
/*
  One programmable interval timer: current interval, accumulated total and,
  optionally, a count of starts. Start and stop strobes come from logic on
  the same clock, so they are used without synchronisers.
*/
`timescale 1ns/1ps

module interval_timer #(
  parameter int WIDTH       = 32,
  parameter bit KEEP_STARTS = 1'b1
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // control
  input  wire logic             enable,
  input  wire logic             clear,
  input  wire logic             start,
  input  wire logic             stop,
  // results
  output logic                  running,
  output logic [WIDTH-1:0]      value,
  output logic [WIDTH-1:0]      total,
  output logic [WIDTH-1:0]      starts
);

  logic             run_r, run_nxt;
  logic [WIDTH-1:0] value_r, value_nxt;
  logic [WIDTH-1:0] total_r, total_nxt;
  logic [WIDTH-1:0] starts_r, starts_nxt;

  always_comb begin
    run_nxt    = run_r;
    value_nxt  = value_r;
    total_nxt  = total_r;
    starts_nxt = starts_r;
    if (clear) begin
      run_nxt    = 1'b0;
      value_nxt  = '0;
      total_nxt  = '0;
      starts_nxt = '0;
    end else if (enable) begin
      if (run_r) begin
        value_nxt = value_r + 1'b1;
        total_nxt = total_r + 1'b1;
      end
      if (start && !run_r) begin
        run_nxt   = 1'b1;
        value_nxt = '0;
        // only the first timer counts starts, for its average
        if (KEEP_STARTS) begin
          starts_nxt = starts_r + 1'b1;
        end
      end else if (stop && run_r) begin
        run_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_r    <= 1'b0;
      value_r  <= '0;
      total_r  <= '0;
      starts_r <= '0;
    end else begin
      run_r    <= run_nxt;
      value_r  <= value_nxt;
      total_r  <= total_nxt;
      starts_r <= starts_nxt;
    end
  end

  assign running = run_r;
  assign value   = value_r;
  assign total   = total_r;
  assign starts  = starts_r;

endmodule

// ===== core/bus_trace_buffer.sv
/*
  Bus trace buffer with two interval timers, registers over AXI4-Lite.
  Assumes the snooped target bus runs on aclk, probe pins are asynchronous,
  and the sequencer supplies state, event and stop strobes on aclk.
*/
// What this block does
// - trace samples live in a circular buffer of 2047 entries.
// - when full, each new sample overwrites the oldest one; capture goes on.
// - every stored entry is 104 bits wide.
// - entry holds address, data, cycle kind, probe levels, sequencer state, flags.
// - entry holds the free-running timestamp latched on its bus cycle.
// - address field is 16 bits, data field 8 bits.
// - cycle kind tells memory read, memory write, instruction fetch apart.
// - entry records sequencer state and whether event or breakpoint occurred.
// - flag codes differ for an event and for the last, breaking event.
// - samples are read by index from 0; lower index is older.
// - with buffer full, index 2046 is always the newest sample.
// - capture only while the target runs and tracing is enabled.
// - host can read the sample count, zero when nothing was captured.
// - two independent timers measure intervals between program events.
// - timer one keeps total time and start count; timer two no count.
`timescale 1ns/1ps
`include "trace_params.svh"

module bus_trace_buffer #(
  parameter int TIMER_W = 32
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // snooped target bus, same clock
  input  wire logic                    bus_valid,
  input  wire logic [15:0]             bus_addr,
  input  wire logic [7:0]              bus_data,
  input  wire trace_pkg::cycle_kind_t  bus_kind,
  input  wire logic                    cpu_running,
  // sequencer
  input  wire logic [`TRC_STATE_W-1:0] seq_state,
  input  wire logic                    seq_event,
  input  wire logic                    seq_last,
  input  wire logic [1:0]              timer_start,
  input  wire logic [1:0]              timer_stop,
  // external probe pins, asynchronous
  input  wire logic [`TRC_PROBE_W-1:0] probe_in,
  // axi4-lite write address and data
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // axi4-lite write response
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output logic [1:0]                   s_axi_bresp,
  // axi4-lite read
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  input  wire logic [7:0]              s_axi_araddr,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  // interrupt
  output logic                         irq
);

  import trace_pkg::*;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // probe synchronisers and filter
  logic [`TRC_PROBE_W-1:0] pr_s1_r, pr_s2_r, pr_s3_r, probe_r, probe_nxt;

  // trace storage
  entry_t mem_r [`TRC_DEPTH];
  ptr_t   wp_r, wp_nxt;
  logic   full_r, full_nxt;
  logic [`TRC_TS_W-1:0] ts_r, ts_nxt;
  logic   capture;
  entry_t new_entry;
  trace_flag_t flag;

  // registers
  logic [31:0]          ctrl_r, ctrl_nxt;
  ptr_t                 index_r, index_nxt;
  logic [`IRQ_W-1:0]    istat_r, istat_nxt, imask_r, imask_nxt, ievt;

  // bus slave state
  logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        do_write, clear_buf, clear_tmr;
  logic [31:0] wmerged;

  // read path
  logic [11:0] count;
  logic [11:0] phys_sum;
  ptr_t        phys;
  entry_t      rd_entry;

  // timers
  logic [1:0]         t_run, t_stop_seen;
  logic [TIMER_W-1:0] t_value [2];
  logic [TIMER_W-1:0] t_total [2];
  logic [TIMER_W-1:0] t_starts [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_timer
      interval_timer #(
        .WIDTH       (TIMER_W),
        .KEEP_STARTS (g == 0)
      ) u_timer (
        .aclk    (aclk),
        .aresetn (aresetn),
        .enable  (ctrl_r[`CTRL_T1_EN + g]),
        .clear   (clear_tmr),
        .start   (timer_start[g]),
        .stop    (timer_stop[g]),
        .running (t_run[g]),
        .value   (t_value[g]),
        .total   (t_total[g]),
        .starts  (t_starts[g])
      );
      assign t_stop_seen[g] = t_run[g] && timer_stop[g] &&
                              ctrl_r[`CTRL_T1_EN + g];
    end
  endgenerate

  // probe change accepted only once the last two stages agree
  always_comb begin
    probe_nxt = probe_r;
    for (int i = 0; i < `TRC_PROBE_W; i++) begin
      if (pr_s2_r[i] == pr_s3_r[i]) begin
        probe_nxt[i] = pr_s3_r[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pr_s1_r <= '0;
      pr_s2_r <= '0;
      pr_s3_r <= '0;
      probe_r <= '0;
    end else begin
      pr_s1_r <= probe_in;
      pr_s2_r <= pr_s1_r;
      pr_s3_r <= pr_s2_r;
      probe_r <= probe_nxt;
    end
  end

  // capture path
  always_comb begin
    capture = bus_valid && cpu_running && ctrl_r[`CTRL_ENABLE];
    // the breaking cycle wins over a plain event
    if (seq_last) begin
      flag = FLAG_LAST;
    end else if (seq_event) begin
      flag = FLAG_EVENT;
    end else begin
      flag = FLAG_NONE;
    end
    new_entry = {bus_addr, bus_data, bus_kind, probe_r, seq_state,
                 flag, ts_r};
    ts_nxt   = ts_r + 1'b1;
    wp_nxt   = wp_r;
    full_nxt = full_r;
    if (clear_buf) begin
      wp_nxt   = '0;
      full_nxt = 1'b0;
    end else if (capture) begin
      // wrap past the last slot; old entries are overwritten
      if (wp_r == `TRC_LAST_INDEX) begin
        wp_nxt   = '0;
        full_nxt = 1'b1;
      end else begin
        wp_nxt = wp_r + 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r   <= '0;
      full_r <= 1'b0;
      ts_r   <= '0;
    end else begin
      wp_r   <= wp_nxt;
      full_r <= full_nxt;
      ts_r   <= ts_nxt;
    end
  end

  // storage has no reset; only entries below the count are meaningful
  always_ff @(posedge aclk) begin
    if (capture && !clear_buf) begin
      mem_r[wp_r] <= new_entry;
    end
  end

  // index to slot: oldest sits at the write pointer once wrapped
  always_comb begin
    count = full_r ? 12'(`TRC_DEPTH) : {1'b0, wp_r};
    if (full_r) begin
      phys_sum = {1'b0, wp_r} + {1'b0, index_r};
      if (phys_sum >= 12'(`TRC_DEPTH)) begin
        phys_sum = phys_sum - 12'(`TRC_DEPTH);
      end
    end else begin
      phys_sum = {1'b0, index_r};
    end
    // an index at or past the count reads stale data, except 2047: zero before a wrap, the oldest entry after
    phys     = phys_sum[`TRC_PTR_W-1:0];
    rd_entry = (phys_sum < 12'(`TRC_DEPTH)) ? mem_r[phys] : '0;
  end

  // bus slave and registers
  assign do_write  = aw_have_r && w_have_r && !bvalid_r;
  assign clear_buf = do_write && (waddr_r == `REG_CTRL) &&
                     wmerged[`CTRL_CLEAR];
  assign clear_tmr = do_write && (waddr_r == `REG_CTRL) &&
                     wmerged[`CTRL_T_CLEAR];

  always_comb begin
    ievt = '0;
    ievt[`IRQ_WRAP]    = capture && !clear_buf && !full_r &&
                         (wp_r == `TRC_LAST_INDEX);
    ievt[`IRQ_LAST]    = capture && seq_last;
    ievt[`IRQ_T1_STOP] = t_stop_seen[0];
    ievt[`IRQ_T2_STOP] = t_stop_seen[1];
    for (int b = 0; b < 4; b++) begin
      wmerged[8*b +: 8] = wstrb_r[b] ? wdata_r[8*b +: 8] : 8'h00;
    end
  end

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt  = w_have_r;
    waddr_nxt   = waddr_r;
    wdata_nxt   = wdata_r;
    wstrb_nxt   = wstrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rresp_nxt   = rresp_r;
    rdata_nxt   = rdata_r;
    ctrl_nxt    = ctrl_r;
    index_nxt   = index_r;
    imask_nxt   = imask_r;
    istat_nxt   = istat_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_nxt = 1'b1;
      waddr_nxt   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_nxt = 1'b1;
      wdata_nxt  = s_axi_wdata;
      wstrb_nxt  = s_axi_wstrb;
    end
    if (do_write) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = RESP_OKAY;
      unique case (waddr_r)
        // clear bits are strobes and never stored
        `REG_CTRL:     ctrl_nxt = {28'h0, wmerged[3:2],
                                   1'b0, wmerged[0]};
        `REG_INDEX:    index_nxt = wmerged[`TRC_PTR_W-1:0];
        `REG_IRQ_MASK: imask_nxt = wmerged[`IRQ_W-1:0];
        `REG_IRQ_STAT: istat_nxt = istat_r & ~wmerged[`IRQ_W-1:0];
        default:       bresp_nxt = RESP_SLVERR;
      endcase
    end
    // a new event beats a clear in the same cycle
    istat_nxt = istat_nxt | ievt;
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      unique case (s_axi_araddr)
        `REG_CTRL:      rdata_nxt = ctrl_r;
        `REG_STATUS:    rdata_nxt = {14'h0, ctrl_r[`CTRL_ENABLE], full_r,
                                     4'h0, count};
        `REG_INDEX:     rdata_nxt = {21'h0, index_r};
        `REG_SAMPLE0:   rdata_nxt = rd_entry[31:0];
        `REG_SAMPLE1:   rdata_nxt = rd_entry[63:32];
        `REG_SAMPLE2:   rdata_nxt = rd_entry[95:64];
        `REG_SAMPLE3:   rdata_nxt = {24'h0, rd_entry[103:96]};
        `REG_IRQ_STAT:  rdata_nxt = {28'h0, istat_r};
        `REG_IRQ_MASK:  rdata_nxt = {28'h0, imask_r};
        `REG_TSTAMP:    rdata_nxt = ts_r[31:0];
        `REG_T1_VALUE:  rdata_nxt = t_value[0];
        `REG_T1_TOTAL:  rdata_nxt = t_total[0];
        `REG_T1_STARTS: rdata_nxt = t_starts[0];
        `REG_T2_VALUE:  rdata_nxt = t_value[1];
        `REG_T2_TOTAL:  rdata_nxt = t_total[1];
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      waddr_r   <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      rvalid_r  <= 1'b0;
      rresp_r   <= 2'h0;
      rdata_r   <= 32'h0000_0000;
      ctrl_r    <= `CTRL_RESET;
      index_r   <= '0;
      imask_r   <= '0;
      istat_r   <= '0;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r  <= w_have_nxt;
      waddr_r   <= waddr_nxt;
      wdata_r   <= wdata_nxt;
      wstrb_r   <= wstrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rresp_r   <= rresp_nxt;
      rdata_r   <= rdata_nxt;
      ctrl_r    <= ctrl_nxt;
      index_r   <= index_nxt;
      imask_r   <= imask_nxt;
      istat_r   <= istat_nxt;
    end
  end

  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready  = !w_have_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign irq           = |(istat_r & imask_r);

endmodule

// ===== test/trace_chk.sv
/*
  Register port checks for the bus trace buffer.
  Assumes it is bound to bus_trace_buffer and sees one clock, aclk.
*/
`timescale 1ns/1ps
module trace_chk (
  // clock and reset
  input wire logic       aclk,
  input wire logic       aresetn,
  // register port
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // interrupt
  input wire logic       irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  sequence s_rd_held; s_axi_rvalid && !s_axi_rready; endsequence
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_rd_answer; s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_rd_hold;
    s_rd_held |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  property p_rd_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_wr_answer; s_wr_both |-> ##2 s_axi_bvalid; endproperty
  property p_wr_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_wr_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_wr_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_reset_idle;
    $rose(aresetn) |-> !s_axi_rvalid && !s_axi_bvalid && !irq && s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved while waiting");
  a_rd_done: assert property (p_rd_done)
    else $error("read answer not released");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  a_wr_hold: assert property (p_wr_hold)
    else $error("write response moved while waiting");
  a_wr_block: assert property (p_wr_block)
    else $error("write taken while response pending");
  a_wr_done: assert property (p_wr_done)
    else $error("write response not released");
  a_reset_idle: assert property (p_reset_idle)
    else $error("port not idle after reset");
endmodule

bind bus_trace_buffer trace_chk chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .irq);

// ===== test/target_bus_model.sv
/*
  Model of the snooped target bus and sequencer: one bus cycle per clock
  while run is high; fields follow a running sequence number.
  Assumes run is driven on the rising edge of aclk.
*/
`timescale 1ns/1ps
module target_bus_model (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // command
  input  wire logic             run,
  // bus and sequencer
  output logic                  bus_valid,
  output logic [15:0]           bus_addr,
  output logic [7:0]            bus_data,
  output trace_pkg::cycle_kind_t bus_kind,
  output logic [3:0]            seq_state,
  output logic                  seq_event,
  output logic                  seq_last
);
  import trace_pkg::*;
  logic [15:0] seq_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r <= 16'h0000;
      bus_valid <= 1'b0;
      bus_addr <= 16'h0000;
      bus_data <= 8'h00;
    end else begin
      bus_valid <= run;
      if (run) begin
        bus_addr <= seq_r;
        bus_data <= seq_r[7:0] ^ 8'h5a;
        bus_kind <= cycle_kind_t'(2'(seq_r % 3));
        seq_state <= seq_r[3:0];
        seq_event <= seq_r[0];
        seq_last <= seq_r[2:0] == 3'h7;
        seq_r <= seq_r + 16'h0001;
      end else begin
        // idle lines must not look like a held last value
        bus_addr <= ~bus_addr;
        bus_data <= ~bus_data;
      end
    end
  end
endmodule

// ===== test/tb.sv
/*
  Self-checking bench for the bus trace buffer and its timers.
  Assumes trace_pkg, the design, the bus model and the checker are compiled.
*/
`timescale 1ns/1ps
`include "trace_params.svh"
module tb;
  import trace_pkg::*;
  logic aclk = 0, aresetn = 0, run = 0, cpu_running = 0;
  logic [1:0] timer_start = 0, timer_stop = 0;
  logic [7:0] probe_in = 8'ha5, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, irq, bus_valid, seq_event, seq_last;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, v1, v2, rd;
  logic [15:0] bus_addr, nseq = 0, base;
  logic [7:0] bus_data;
  logic [3:0] seq_state;
  cycle_kind_t bus_kind;
  logic [1:0] rsp, wrsp;
  logic [63:0] ts, prev;
  int errors = 0, checked = 0;
  always #50 aclk = ~aclk;
  bus_trace_buffer dut_u (.aclk, .aresetn, .bus_valid, .bus_addr, .bus_data,
    .bus_kind, .cpu_running, .seq_state, .seq_event, .seq_last, .timer_start,
    .timer_stop, .probe_in, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .irq);
  target_bus_model model_u (.aclk, .aresetn, .run, .bus_valid, .bus_addr,
    .bus_data, .bus_kind, .seq_state, .seq_event, .seq_last);
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ready is settled at the falling edge and cannot move before the next rise
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic ad, wd, ah, wh, bh;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awvalid <= 1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1;
    s_axi_wdata <= d;
    s_axi_bready <= 1;
    do begin
      @(negedge aclk);
      ah = !ad && s_axi_awready === 1'b1;
      wh = !wd && s_axi_wready === 1'b1;
      bh = s_axi_bvalid === 1'b1;
      wrsp = s_axi_bresp;
      @(posedge aclk);
      if (ah) begin ad = 1; s_axi_awvalid <= 0; end
      if (wh) begin wd = 1; s_axi_wvalid <= 0; end
    end while (!bh);
    s_axi_bready <= 0;
  endtask
  task automatic rdr(logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ah, rh;
    @(posedge aclk);
    s_axi_arvalid <= 1;
    s_axi_araddr <= a;
    s_axi_rready <= 1;
    do begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready === 1'b1;
      rh = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 0;
    end while (!rh);
    s_axi_rready <= 0;
  endtask
  task automatic run_cycles(int k);
    @(posedge aclk);
    run <= 1;
    repeat (k) @(posedge aclk);
    run <= 0;
    nseq += 16'(k);
    repeat (3) @(posedge aclk);
  endtask
  task automatic chk_entry(logic [10:0] idx, logic [15:0] n);
    logic [127:0] e;
    wr(`REG_INDEX, {21'h0, idx});
    for (int i = 0; i < 4; i++) begin
      rdr(8'(`REG_SAMPLE0 + 4 * i), rd, rsp);
      e[32*i +: 32] = rd;
    end
    ts = e[63:0];
    chk("addr", n, e[103:88]);
    chk("data", n[7:0] ^ 8'h5a, e[87:80]);
    chk("kind", n % 3, e[79:78]);
    chk("probe", probe_in, e[77:70]);
    chk("state", n[3:0], e[69:66]);
    chk("flag", n[2:0] == 3'h7 ? 2 : n[0], e[65:64]);
    chk("pad", 0, e[127:104]);
  endtask
  task automatic stop_test();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    $display("[FAIL] watchdog expected finish seen hang");
    stop_test();
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    rdr(`REG_STATUS, rd, rsp);
    chk("count", 0, rd);
    rdr(`REG_CTRL, rd, rsp);
    chk("ctrl", 0, rd);
    cpu_running <= 1;
    run_cycles(4);
    wr(`REG_CTRL, 1);
    chk("wr resp", 0, wrsp);
    cpu_running <= 0;
    run_cycles(4);
    rdr(`REG_STATUS, rd, rsp);
    chk("count off", 32'h0002_0000, rd);
    $display("test reset and gating done");
    cpu_running <= 1;
    base = nseq;
    run_cycles(9);
    rdr(`REG_STATUS, rd, rsp);
    chk("count", 32'h0002_0009, rd);
    for (int i = 0; i < 9; i++) begin
      chk_entry(11'(i), base + 16'(i));
      if (i > 0) chk("stamp", prev[31:0] + 1, ts[31:0]);
      prev = ts;
    end
    chk("irq masked", 0, irq);
    $display("test capture done");
    wr(`REG_IRQ_MASK, 1);
    // new probe level settles through the filter long before capture
    probe_in <= 8'h3c;
    wr(`REG_CTRL, 3);
    rdr(`REG_STATUS, rd, rsp);
    chk("cleared", 32'h0002_0000, rd);
    base = nseq;
    run_cycles(`TRC_DEPTH + 5);
    rdr(`REG_STATUS, rd, rsp);
    chk("full", 32'h0003_07ff, rd);
    chk_entry(0, base + 5);
    chk_entry(`TRC_LAST_INDEX, base + 16'(`TRC_DEPTH + 4));
    chk("irq", 1, irq);
    rdr(`REG_IRQ_STAT, rd, rsp);
    chk("wrap stat", 3, rd & 3);
    wr(`REG_IRQ_STAT, 1);
    chk("irq cleared", 0, irq);
    wr(`REG_IRQ_STAT, 32'hf);
    $display("test wrap done");
    wr(`REG_CTRL, 32'hc);
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      timer_start <= k ? 2'b01 : 2'b11;
      @(posedge aclk);
      timer_start <= 0;
      repeat (10 - 4 * k) @(posedge aclk);
      timer_stop <= 2'b11;
      @(posedge aclk);
      timer_stop <= 0;
      repeat (2) @(posedge aclk);
      rdr(`REG_T1_VALUE, v2, rsp);
      if (k == 0) v1 = v2;
    end
    chk("t1 runs", 32'h000b_0007, {v1[15:0], v2[15:0]});
    rdr(`REG_T1_TOTAL, rd, rsp);
    chk("t1 total", v1 + v2, rd);
    rdr(`REG_T1_STARTS, rd, rsp);
    chk("t1 starts", 2, rd);
    rdr(`REG_T2_TOTAL, rd, rsp);
    chk("t2 total", v1, rd);
    rdr(`REG_T2_VALUE, rd, rsp);
    chk("t2 value", v1, rd);
    wr(8'h3c, 0);
    chk("bad wr resp", 2'b10, wrsp);
    rdr(8'h3c, rd, rsp);
    chk("t2 starts absent", 2'b10, rsp);
    rdr(`REG_IRQ_STAT, rd, rsp);
    chk("timer stat", 32'hc, rd);
    wr(`REG_CTRL, 32'h1c);
    rdr(`REG_T1_STARTS, rd, rsp);
    chk("t1 cleared", 0, rd);
    $display("test timers done");
    stop_test();
  end
endmodule
